// ### dv/serial_loopback_echo_crc_command_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the loopback/echo/CRC command block
module serial_loopback_echo_crc_command_tb_top;
  // Bus, pins and side signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rxd_pin, cts_pin, carrier_detect_pin, txd_pin, er;
  logic tx_data, tx_underrun, crc_tx_start, rx_frame_start;
  logic rx_data, rx_enable, tx_enable, rx_crc_init, tx_crc_init;
  logic append_crc, send_abort, loop_data_in, loop_enable;
  logic loop_source, loop_mode, ext_status_irq, underrun_eom, heard;
  logic [2:0] want;
  // Line history for the routing model
  logic hr [32];
  logic hc [32];
  logic hd [32];
  logic ht [32];
  // Loop command table and expected {enable, source, mode}
  logic [2:0] lcmd [6];
  logic [2:0] lexp [6];
  int checks, miscompares, cyc, k, m, seed;

  sle_core sle_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_pin(rxd_pin), .cts_pin(cts_pin),
    .carrier_detect_pin(carrier_detect_pin), .txd_pin(txd_pin), .tx_data(tx_data),
    .tx_underrun(tx_underrun), .crc_tx_start(crc_tx_start), .rx_frame_start(rx_frame_start),
    .rx_data(rx_data), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .rx_crc_init(rx_crc_init), .tx_crc_init(tx_crc_init), .append_crc(append_crc),
    .send_abort(send_abort), .loop_data_in(loop_data_in), .loop_enable(loop_enable),
    .loop_source(loop_source), .loop_mode(loop_mode), .ext_status_irq(ext_status_irq),
    .underrun_eom(underrun_eom));

  sle_remote sle_remote_i (.pclk(pclk), .presetn(presetn), .want(want), .txd_pin(txd_pin), .heard(heard),
    .rxd_pin(rxd_pin), .cts_pin(cts_pin), .carrier_detect_pin(carrier_detect_pin));

  // 125 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Hang guard, far above the few hundred cycles needed
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  // Counted comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; held until pready is sampled high, only the hang guard ends a wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write, then stand in the cycle where pulses show
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(negedge pclk);
  endtask

  // One-cycle event {underrun, crc start, frame start}
  task automatic pulse(input logic [2:0] p);
    @(posedge pclk);
    {tx_underrun, crc_tx_start, rx_frame_start} <= p;
    @(posedge pclk);
    {tx_underrun, crc_tx_start, rx_frame_start} <= 3'h0;
    @(negedge pclk);
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    seed = 32'h2647;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want = 3'h4;
    tx_data = 1'b0;
    {tx_underrun, crc_tx_start, rx_frame_start} = 3'h0;
    lcmd = '{sle_pkg::LOOP_SRC_GEN, sle_pkg::LOOP_FM, sle_pkg::LOOP_SEARCH,
      sle_pkg::LOOP_SRC_PIN, sle_pkg::LOOP_NRZI, sle_pkg::LOOP_DISABLE};
    lexp = '{3'h2, 3'h3, 3'h7, 3'h5, 3'h4, 3'h0};
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({loop_enable, loop_source, loop_mode}, {1'b0, sle_pkg::SRC_PIN, sle_pkg::MODE_NRZI});
    chk(underrun_eom, sle_pkg::LATCH_RESET);
    apb(1'b0, sle_pkg::OFS_STAT, 32'h0);
    chk(rd & 32'h39, 32'h01);
    // Source, then mode, then search, as a host should
    for (k = 0; k < 6; k++)
    begin
      wr(sle_pkg::OFS_MISC, {24'h0, lcmd[k], 5'h0});
      chk({loop_enable, loop_source, loop_mode}, lexp[k]);
    end
    for (k = 0; k < 3; k++)
      wr(sle_pkg::OFS_MISC, {24'h0, lcmd[k], 5'h0});
    wr(sle_pkg::OFS_CTRL, 32'h80);
    chk({loop_enable, loop_source, loop_mode}, 3'h0);
    chk(tx_crc_init, 1'b0);
    // Transmitter on before any generator reset
    wr(sle_pkg::OFS_CTRL, 32'h03);
    for (k = 0; k < 4; k++)
    begin
      wr(sle_pkg::OFS_CMD, {24'h0, k[1:0], 6'h0});
      chk(rx_crc_init, k == 1);
      chk(tx_crc_init, k == 2);
      chk(underrun_eom, k != 3);
    end
    pulse(3'h4);
    chk({append_crc, send_abort}, 2'b10);
    pulse(3'h2);
    chk(underrun_eom, 1'b1);
    pulse(3'h4);
    chk(append_crc, 1'b0);
    wr(sle_pkg::OFS_CMD, 32'hc0);
    chk(underrun_eom, 1'b0);
    wr(sle_pkg::OFS_CTRL, 32'h0f);
    pulse(3'h4);
    chk({append_crc, send_abort}, 2'b01);
    pulse(3'h1);
    chk(rx_crc_init, 1'b1);
    wr(sle_pkg::OFS_CTRL, 32'h0e);
    chk(rx_crc_init, 1'b1);
    // Latch clear with the transmitter off
    wr(sle_pkg::OFS_CTRL, 32'h00);
    pulse(3'h2);
    wr(sle_pkg::OFS_CMD, 32'hc0);
    chk(underrun_eom, 1'b1);
    chk(ext_status_irq, 1'b1);
    apb(1'b0, sle_pkg::OFS_STAT, 32'h0);
    chk(rd & 32'h07, 32'h03);
    wr(sle_pkg::OFS_CMD, 32'hc0);
    chk(ext_status_irq, 1'b0);
    wr(sle_pkg::OFS_CMD, 32'hd0);
    chk(ext_status_irq, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    wr(sle_pkg::OFS_CTRL, 32'h13);
    apb(1'b0, sle_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h13);
    // Routing in all four {loopback, echo} settings with random lines
    for (m = 0; m < 4; m++)
    begin
      wr(sle_pkg::OFS_MISC, {24'h0, 3'h0, m[1], m[0], 3'h0});
      for (k = 0; k < 24; k++)
      begin
        @(posedge pclk);
        want <= 3'($random(seed));
        tx_data <= 1'($random(seed));
        @(negedge pclk);
        {hr[k], hc[k], hd[k], ht[k]} = {rxd_pin, cts_pin, carrier_detect_pin, tx_data};
        if (k > 5)
        begin
          chk(rx_data, (m == 2) ? ht[k-1] : hr[k-3]);
          chk(txd_pin, m[0] ? hr[k-3] : ht[k-1]);
          chk(loop_data_in, hr[k-3]);
          chk(heard, m[0] ? hr[k-4] : ht[k-2]);
          chk(rx_enable, m[1] ? 1'b1 : hd[k-3]);
          chk(tx_enable, (m != 0) ? 1'b1 : hc[k-3]);
        end
      end
    end
    complete_run();
  end
endmodule // serial_loopback_echo_crc_command_tb_top

// ### dv/sle_remote.sv
`timescale 1ns/1ps
// Far station on the serial lines
module sle_remote
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench request: line bit, clear-to-send, carrier
  input wire logic [2:0] want,
  // Line from the device
  input wire logic txd_pin,
  // Line as heard back, one cycle late
  output logic heard,
  // Lines toward the device
  output logic rxd_pin,
  output logic cts_pin,
  output logic carrier_detect_pin
);
  // Last bit heard from the device
  logic heard_reg;
  // Bench compares what the far end heard
  assign heard = heard_reg;
  // Lines move just after an edge; idle line is mark, modem lines off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_pin <= 1'b1;
      cts_pin <= 1'b0;
      carrier_detect_pin <= 1'b0;
      heard_reg <= 1'b1;
    end
    else
    begin
      {rxd_pin, cts_pin, carrier_detect_pin} <= want;
      heard_reg <= txd_pin;
    end
  end
endmodule // sle_remote

// ### rtl/sle_core.sv
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Any reset: loop off, pin source, NRZI
// - Search command enables the clock-recovery loop
// - Loopback: transmitter feeds receiver, pin keeps transmitter
// - Loopback ignores carrier and clear-to-send enables
// - Loop input always from serial input pin
// - Echo: input pin to output and receiver
// - Echo ignores clear-to-send; transmitter output dropped
// - Both set: echo, ignore both enables
// - CRC code 00 does nothing
// - CRC code 01 initialises receive checker
// - Receiver disable initialises receive checker
// - SDLC resets receive checker automatically
// - Code 10 inits transmit generator; channel reset not
// - Code 11 clears latch; underrun appends CRC
// - SDLC abort-on-underrun sends abort then flag
// - CRC start sets latch; clear only with transmitter enabled
// - Transmitter disabled: latch clear ignored
// - Disabled clear raises status interrupt only if none pending or with reset ext/status command
module sle_core
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins, asynchronous
  input wire logic rxd_pin,
  input wire logic cts_pin,
  input wire logic carrier_detect_pin,
  output logic txd_pin,
  // Transmitter and receiver side, same clock
  input wire logic tx_data,
  input wire logic tx_underrun,
  input wire logic crc_tx_start,
  input wire logic rx_frame_start,
  output logic rx_data,
  output logic rx_enable,
  output logic tx_enable,
  output logic rx_crc_init,
  output logic tx_crc_init,
  output logic append_crc,
  output logic send_abort,
  // Clock-recovery loop control
  output logic loop_data_in,
  output logic loop_enable,
  output logic loop_source,
  output logic loop_mode,
  // Status events
  output logic ext_status_irq,
  output logic underrun_eom
);

  sle_pkg::sle_state_s s_reg; // Registered state
  sle_pkg::sle_state_s s_next; // Next state
  logic access; // APB access phase with answer given
  logic wr_cmd; // Write to channel command
  logic wr_misc; // Write to misc control
  logic wr_ctrl; // Write to channel control
  logic ch_reset; // Channel reset strobe
  sle_pkg::sle_crc_e crc_code; // CRC reset code of a command write
  logic [2:0] op_code; // Command code of a command write
  logic [2:0] loop_op; // Loop command of a misc write
  logic mapped; // Address hits a register

  // Decode of the bus transfer; effects land only on the pready edge
  assign access = psel && penable && s_reg.pready;
  assign wr_cmd = access && pwrite && (paddr == sle_pkg::OFS_CMD);
  assign wr_misc = access && pwrite && (paddr == sle_pkg::OFS_MISC);
  assign wr_ctrl = access && pwrite && (paddr == sle_pkg::OFS_CTRL);
  assign ch_reset = wr_ctrl && pwdata[sle_pkg::CTRL_CH_RESET];
  assign crc_code = sle_pkg::sle_crc_e'(pwdata[sle_pkg::CMD_CRC_HI:sle_pkg::CMD_CRC_LO]);
  assign op_code = pwdata[sle_pkg::CMD_OP_HI:sle_pkg::CMD_OP_LO];
  assign loop_op = pwdata[sle_pkg::MISC_OP_HI:sle_pkg::MISC_OP_LO];
  assign mapped = (paddr == sle_pkg::OFS_CMD) || (paddr == sle_pkg::OFS_MISC) ||
                  (paddr == sle_pkg::OFS_CTRL) || (paddr == sle_pkg::OFS_STAT);

  // Next-state logic for the whole block
  always_comb
  begin
    logic rx_en_cur;
    logic tx_en_cur;
    logic mode_lb;
    logic mode_echo;
    logic reset_ext;
    s_next = s_reg;
    rx_en_cur = s_reg.ctrl[sle_pkg::CTRL_RX_EN];
    tx_en_cur = s_reg.ctrl[sle_pkg::CTRL_TX_EN];
    mode_lb = s_reg.loopback;
    mode_echo = s_reg.echo;
    reset_ext = wr_cmd && (op_code == sle_pkg::OP_RESET_EXT);
    // Pulses last one cycle
    s_next.rx_crc_init = 1'b0;
    s_next.tx_crc_init = 1'b0;
    s_next.append_crc = 1'b0;
    s_next.send_abort = 1'b0;
    s_next.ext_irq = 1'b0;
    // Two-stage synchronisers on the asynchronous pins
    s_next.rxd_sync = {s_reg.rxd_sync[0], rxd_pin};
    s_next.cts_sync = {s_reg.cts_sync[0], cts_pin};
    s_next.dcd_sync = {s_reg.dcd_sync[0], carrier_detect_pin};

    // APB answer: one wait state, then pready for a single cycle
    s_next.pready = psel && penable && !s_reg.pready;
    s_next.pslverr = psel && penable && !s_reg.pready && !mapped;
    s_next.prdata = '0;
    if (psel && penable && !s_reg.pready && !pwrite)
    begin
      // Only control and status read back; write-only registers read zero
      if (paddr == sle_pkg::OFS_CTRL)
      begin
        s_next.prdata = {27'h0000000, s_reg.ctrl};
      end
      else if (paddr == sle_pkg::OFS_STAT)
      begin
        s_next.prdata = {24'h000000, s_reg.echo, s_reg.loopback, s_reg.loop_mode,
                         s_reg.loop_src, s_reg.loop_en, s_reg.ext_snap_ur,
                         s_reg.ext_pend, s_reg.latch};
      end
      else
      begin
        s_next.prdata = '0;
      end
    end

    // Channel control; a channel reset overrides the written value
    if (wr_ctrl)
    begin
      s_next.ctrl = pwdata[sle_pkg::CTRL_AUTO_EN:sle_pkg::CTRL_RX_EN];
    end
    if (ch_reset)
    begin
      // Loop back to its defaults, diagnostics off
      s_next.ctrl = sle_pkg::CTRL_RESET;
      s_next.loop_en = 1'b0;
      s_next.loop_src = sle_pkg::SRC_PIN;
      s_next.loop_mode = sle_pkg::MODE_NRZI;
      s_next.loopback = 1'b0;
      s_next.echo = 1'b0;
      // Transmit generator deliberately left alone here
    end

    // Misc control: diagnostic routing bits and loop commands
    if (wr_misc && !ch_reset)
    begin
      s_next.loopback = pwdata[sle_pkg::MISC_LOOPBACK];
      s_next.echo = pwdata[sle_pkg::MISC_ECHO];
      case (loop_op)
        sle_pkg::LOOP_SEARCH: s_next.loop_en = 1'b1;
        sle_pkg::LOOP_DISABLE: s_next.loop_en = 1'b0;
        sle_pkg::LOOP_SRC_GEN: s_next.loop_src = sle_pkg::SRC_GEN;
        sle_pkg::LOOP_SRC_PIN: s_next.loop_src = sle_pkg::SRC_PIN;
        sle_pkg::LOOP_FM: s_next.loop_mode = sle_pkg::MODE_FM;
        sle_pkg::LOOP_NRZI: s_next.loop_mode = sle_pkg::MODE_NRZI;
        default: s_next.loop_en = s_reg.loop_en; // Null and unused codes
      endcase
    end

    // Receive CRC checker initialisation sources
    if (wr_cmd && (crc_code == sle_pkg::CRC_RX_INIT))
    begin
      s_next.rx_crc_init = 1'b1;
    end
    if (rx_en_cur && !s_next.ctrl[sle_pkg::CTRL_RX_EN])
    begin
      s_next.rx_crc_init = 1'b1;
    end
    if (s_reg.ctrl[sle_pkg::CTRL_SDLC] && rx_frame_start)
    begin
      s_next.rx_crc_init = 1'b1;
    end

    // Transmit CRC generator: only the explicit code starts it over
    if (wr_cmd && (crc_code == sle_pkg::CRC_TX_INIT))
    begin
      s_next.tx_crc_init = 1'b1;
    end

    // Underrun/END_OF_MESSAGE latch; code 00 matches no branch and changes nothing
    if (wr_cmd && (crc_code == sle_pkg::CRC_LATCH_CLR))
    begin
      if (tx_en_cur)
      begin
        s_next.latch = 1'b0;
      end
      else if (!s_reg.ext_pend || reset_ext)
      begin
        // Latch kept, but status interrupt reports it clear
        s_next.ext_irq = 1'b1;
        s_next.ext_snap_ur = 1'b0;
      end
      else
      begin
        s_next.latch = s_reg.latch;
      end
    end
    if (crc_tx_start)
    begin
      // Set wins over a clear in the same cycle
      s_next.latch = 1'b1;
    end

    // Underrun with latch clear ends the frame
    if (tx_underrun && !s_reg.latch)
    begin
      if (s_reg.ctrl[sle_pkg::CTRL_SDLC] && s_reg.ctrl[sle_pkg::CTRL_ABORT_UR])
      begin
        s_next.send_abort = 1'b1;
      end
      else
      begin
        s_next.append_crc = 1'b1;
      end
    end

    // Pending flag: the command clears, a new event sets and wins
    if (reset_ext)
    begin
      s_next.ext_pend = 1'b0;
    end
    if (s_next.ext_irq)
    begin
      s_next.ext_pend = 1'b1;
    end

    // Serial routing; echo takes priority when both bits are set
    s_next.loop_in = s_reg.rxd_sync[1];
    if (mode_echo)
    begin
      s_next.ser_out = s_reg.rxd_sync[1];
      s_next.rx_data = s_reg.rxd_sync[1];
    end
    else if (mode_lb)
    begin
      s_next.ser_out = tx_data;
      s_next.rx_data = tx_data;
    end
    else
    begin
      s_next.ser_out = tx_data;
      s_next.rx_data = s_reg.rxd_sync[1];
    end

    // Effective enables; loopback masks both modem pins, echo masks only clear-to-send
    s_next.rx_en_eff = rx_en_cur;
    s_next.tx_en_eff = tx_en_cur;
    if (s_reg.ctrl[sle_pkg::CTRL_AUTO_EN])
    begin
      if (!mode_lb)
      begin
        // Carrier gates receive only outside loopback
        s_next.rx_en_eff = rx_en_cur && s_reg.dcd_sync[1];
      end
      if (!mode_lb && !mode_echo)
      begin
        s_next.tx_en_eff = tx_en_cur && s_reg.cts_sync[1];
      end
    end
  end

  // State register; asynchronous reset to constants only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.loop_en <= 1'b0;
      s_reg.loop_src <= sle_pkg::SRC_PIN;
      s_reg.loop_mode <= sle_pkg::MODE_NRZI;
      s_reg.ctrl <= sle_pkg::CTRL_RESET;
      s_reg.latch <= sle_pkg::LATCH_RESET;
      s_reg.ext_snap_ur <= sle_pkg::LATCH_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign txd_pin = s_reg.ser_out;
  assign rx_data = s_reg.rx_data;
  assign rx_enable = s_reg.rx_en_eff;
  assign tx_enable = s_reg.tx_en_eff;
  assign rx_crc_init = s_reg.rx_crc_init;
  assign tx_crc_init = s_reg.tx_crc_init;
  assign append_crc = s_reg.append_crc;
  assign send_abort = s_reg.send_abort;
  assign loop_data_in = s_reg.loop_in;
  assign loop_enable = s_reg.loop_en;
  assign loop_source = s_reg.loop_src;
  assign loop_mode = s_reg.loop_mode;
  assign ext_status_irq = s_reg.ext_irq;
  assign underrun_eom = s_reg.latch;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_clr_disabled;
    wr_cmd && (crc_code == sle_pkg::CRC_LATCH_CLR) && !s_reg.ctrl[sle_pkg::CTRL_TX_EN];
  endsequence

  property p_reset_loop;
    ch_reset |=> !loop_enable && (loop_source == sle_pkg::SRC_PIN) && (loop_mode == sle_pkg::MODE_NRZI);
  endproperty
  a_reset_loop: assert property (p_reset_loop) else $error("Loop not defaulted by channel reset");

  property p_search;
    wr_misc && !ch_reset && (loop_op == sle_pkg::LOOP_SEARCH) |=> loop_enable;
  endproperty
  a_search: assert property (p_search) else $error("Search command did not enable loop");

  property p_loopback;
    s_reg.loopback && !s_reg.echo |=> (rx_data == $past(tx_data)) && (txd_pin == $past(tx_data));
  endproperty
  a_loopback: assert property (p_loopback) else $error("Loopback routing wrong");

  property p_lb_enables;
    s_reg.loopback && s_reg.ctrl[sle_pkg::CTRL_RX_EN] && s_reg.ctrl[sle_pkg::CTRL_TX_EN] |=> rx_enable && tx_enable;
  endproperty
  a_lb_enables: assert property (p_lb_enables) else $error("Modem pin gated loopback");

  property p_loop_input;
    ##1 1'b1 |-> loop_data_in == $past(s_reg.rxd_sync[1]);
  endproperty
  a_loop_input: assert property (p_loop_input) else $error("Loop input not from pin");

  property p_echo;
    s_reg.echo |=> (txd_pin == $past(s_reg.rxd_sync[1])) && (rx_data == txd_pin);
  endproperty
  a_echo: assert property (p_echo) else $error("Echo routing wrong");

  property p_echo_cts;
    s_reg.echo && s_reg.ctrl[sle_pkg::CTRL_TX_EN] |=> tx_enable;
  endproperty
  a_echo_cts: assert property (p_echo_cts) else $error("Clear-to-send gated echo");

  property p_null_code;
    wr_cmd && (crc_code == sle_pkg::CRC_NULL) |=> !tx_crc_init;
  endproperty
  a_null_code: assert property (p_null_code) else $error("Null code had an effect");

  property p_rx_init;
    wr_cmd && (crc_code == sle_pkg::CRC_RX_INIT) |=> rx_crc_init ##1 !rx_crc_init [*1];
  endproperty
  a_rx_init: assert property (p_rx_init) else $error("Receive CRC not initialised");

  property p_rx_disable;
    $fell(s_reg.ctrl[sle_pkg::CTRL_RX_EN]) |-> rx_crc_init;
  endproperty
  a_rx_disable: assert property (p_rx_disable) else $error("Receiver disable kept CRC");

  property p_sdlc_auto;
    s_reg.ctrl[sle_pkg::CTRL_SDLC] && rx_frame_start |=> rx_crc_init;
  endproperty
  a_sdlc_auto: assert property (p_sdlc_auto) else $error("SDLC frame kept receive CRC");

  property p_tx_init;
    tx_crc_init |-> $past(wr_cmd) && ($past(crc_code) == sle_pkg::CRC_TX_INIT);
  endproperty
  a_tx_init: assert property (p_tx_init) else $error("Transmit CRC init without command");

  property p_underrun;
    tx_underrun && !s_reg.latch |=> append_crc != send_abort;
  endproperty
  a_underrun: assert property (p_underrun) else $error("Underrun not acted on");

  property p_abort;
    tx_underrun && !s_reg.latch && s_reg.ctrl[sle_pkg::CTRL_SDLC] && s_reg.ctrl[sle_pkg::CTRL_ABORT_UR] |=> send_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("Abort not sent on underrun");

  property p_crc_start;
    crc_tx_start |=> underrun_eom;
  endproperty
  a_crc_start: assert property (p_crc_start) else $error("CRC start did not set latch");

  property p_disabled_clear;
    s_clr_disabled and (s_reg.latch && (!s_reg.ext_pend || (op_code == sle_pkg::OP_RESET_EXT)))
      |=> underrun_eom && ext_status_irq && !s_reg.ext_snap_ur;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear) else $error("Disabled clear misbehaved");

endmodule // sle_core

// ### rtl/sle_pkg.sv
// Shared constants and carriers for the loopback/echo/CRC command block
package sle_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00; // Channel command, write only
  localparam logic [7:0] OFS_MISC = 8'h04; // Misc channel control, write only
  localparam logic [7:0] OFS_CTRL = 8'h08; // Channel control, read/write
  localparam logic [7:0] OFS_STAT = 8'h0c; // Channel status, read only
  // Channel command fields
  localparam int CMD_CRC_HI = 7; // CRC reset code, top bit
  localparam int CMD_CRC_LO = 6; // CRC reset code, low bit
  localparam int CMD_OP_HI = 5; // Command code, top bit
  localparam int CMD_OP_LO = 3; // Command code, low bit
  localparam logic [2:0] OP_RESET_EXT = 3'h2; // Reset external/status interrupt
  // Misc channel control fields
  localparam int MISC_OP_HI = 7; // Loop command, top bit
  localparam int MISC_OP_LO = 5; // Loop command, low bit
  localparam int MISC_LOOPBACK = 4; // Local loopback select
  localparam int MISC_ECHO = 3; // Auto echo select
  localparam logic [2:0] LOOP_SEARCH = 3'h1; // Enter search mode, enables loop
  localparam logic [2:0] LOOP_DISABLE = 3'h3; // Disable loop
  localparam logic [2:0] LOOP_SRC_GEN = 3'h4; // Source: internal rate generator
  localparam logic [2:0] LOOP_SRC_PIN = 3'h5; // Source: combined clock pin
  localparam logic [2:0] LOOP_FM = 3'h6; // FM mode
  localparam logic [2:0] LOOP_NRZI = 3'h7; // NRZI mode
  // Channel control fields
  localparam int CTRL_RX_EN = 0; // Receiver enable
  localparam int CTRL_TX_EN = 1; // Transmitter enable
  localparam int CTRL_SDLC = 2; // SDLC mode
  localparam int CTRL_ABORT_UR = 3; // Abort on underrun
  localparam int CTRL_AUTO_EN = 4; // Auto enables
  localparam int CTRL_CH_RESET = 7; // Channel reset, write one, reads zero
  localparam logic [4:0] CTRL_RESET = 5'h00; // Control reset value
  // Loop source and mode encodings
  localparam logic SRC_PIN = 1'b0; // Combined rx/tx clock pin
  localparam logic SRC_GEN = 1'b1; // Internal rate generator
  localparam logic MODE_NRZI = 1'b0; // NRZI
  localparam logic MODE_FM = 1'b1; // FM
  localparam logic LATCH_RESET = 1'b1; // Underrun/END_OF_MESSAGE latch after power-up
  // CRC reset codes
  typedef enum logic [1:0] {
    CRC_NULL = 2'b00,
    CRC_RX_INIT = 2'b01,
    CRC_TX_INIT = 2'b10,
    CRC_LATCH_CLR = 2'b11
  } sle_crc_e;
  // Whole block state
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [4:0] ctrl; // rx_en, tx_en, sdlc, abort_ur, auto_en
    logic loopback;
    logic echo;
    logic loop_en;
    logic loop_src;
    logic loop_mode;
    logic latch; // Underrun/END_OF_MESSAGE latch
    logic ext_pend; // External/status interrupt pending
    logic ext_snap_ur; // Underrun bit as reported with the interrupt
    logic [1:0] rxd_sync; // [0] first stage, [1] second stage
    logic [1:0] cts_sync;
    logic [1:0] dcd_sync;
    logic ser_out;
    logic rx_data;
    logic loop_in;
    logic rx_en_eff;
    logic tx_en_eff;
    logic rx_crc_init;
    logic tx_crc_init;
    logic append_crc;
    logic send_abort;
    logic ext_irq;
  } sle_state_s;
endpackage
